// ---- scmcir_regs.sv ----
// Register slice: third module clock and answer windows, version, interrupt summary, device settings
//
// Overview of operation
// - Oscillator select bit 7 drives card clock near 1.2 MHz, above all else.
// - With bit 7 clear, force-low bit 6 holds card clock at 0.
// - With bits 7 and 6 clear, force-high bit 5 holds card clock at 1.
// - Divider bits 4:2 give /1,/2,/4,/5, else /8; resets to 011.
// - Early window is ten bits: high byte resets aa, low bits 7:6 reset 00.
// - Mute window is sixteen bits: high byte resets a4, low byte 74.
// - Summary bit 7 sets on any user card fault or presence flag.
// - Summary bits 6,5,4 set on faults of modules one, two, three.
// - Summary bit 3 sets on over-temperature shutdown of all interfaces.
// - Summary bit 2 sets on supply supervisor shutdown of all interfaces.
// - Summary bit 1 sets when synchronous activation completes.
// - Summary bit 0 sets when an input-configured general pin changes level.
// - Interrupt pin is low while any summary bit is set.
// - Reading the summary register clears each set bit whose source is no longer present.
// - Device settings bit 7 enables the boost converter; resets to 1.
// - Device settings bits 5:2 set pin four..one direction, 1 input; reset 0.
// - A masked event neither sets its summary bit nor pulls the pin low.
// - An output level bit is ignored while its pin is an input.
`timescale 1ns/100ps
module scmcir_regs #(
  parameter logic [7:0] VERSION_CODE = 8'h5a  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [4:0]  user_card_flags,
  input  wire logic [3:0]  first_module_flags,
  input  wire logic [3:0]  second_module_flags,
  input  wire logic [3:0]  third_module_flags,
  input  wire logic        over_temp_event,
  input  wire logic        supervisor_fault_event,
  input  wire logic        sync_complete_event,
  input  wire logic [3:0]  gpio_in,
  output logic      [3:0]  gpio_out,
  output logic      [3:0]  gpio_oe,
  output logic             int_n,
  output logic             boost_converter_enable,
  input  wire logic        module_input_clock,
  output logic             third_module_card_clock,
  output logic      [9:0]  third_module_soon_window,
  output logic      [15:0] third_module_silence_window
);

  // Register hit for an access of either kind
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] clk_sel_ff,    nxt_clk_sel;
  logic [7:0] soon_hi_ff,    nxt_soon_hi;
  logic [1:0] soon_lo_ff,    nxt_soon_lo;
  logic [7:0] silence_hi_ff, nxt_silence_hi;
  logic [7:0] silence_lo_ff, nxt_silence_lo;
  logic [7:0] summary_ff,    nxt_summary;
  logic [7:0] dev_set_ff,    nxt_dev_set;
  logic [3:0] gpio_lvl_ff,   nxt_gpio_lvl;
  logic [7:0] mask_uc_ff,    nxt_mask_uc;
  logic [7:0] mask_m12_ff,   nxt_mask_m12;
  logic [7:0] mask_m3_ff,    nxt_mask_m3;
  logic [7:0] rdata_ff,      nxt_rdata;
  logic       rvalid_ff,     nxt_rvalid;
  logic       int_n_ff,      nxt_int_n;
  logic [3:0] gpio_out_ff,   nxt_gpio_out;
  logic [3:0] gpio_oe_ff,    nxt_gpio_oe;

  // Pin synchronisers; the first stage is read only by the second
  logic [3:0] gpio_meta_ff;
  logic [3:0] gpio_sync_ff;
  logic [3:0] gpio_prev_ff;

  logic [7:0] set_bits;
  logic [3:0] gpio_dir;
  logic [3:0] gpio_change;

  scmcir_clk_if clk_bus ();

  ////////////////////////////////////////////////////////////////////////////////
  // Card clock generator
  assign clk_bus.osc_select = clk_sel_ff[scmcir_pkg::BIT_OSC_SEL];
  assign clk_bus.force_low  = clk_sel_ff[scmcir_pkg::BIT_FORCE_LOW];
  assign clk_bus.force_high = clk_sel_ff[scmcir_pkg::BIT_FORCE_HIGH];
  assign clk_bus.divider    = clk_sel_ff[scmcir_pkg::BIT_DIV_LSB +: 3];

  scmcir_clkgen #(
    .CNT_W (4)
  ) u_clkgen (
    .clk                (clk),
    .resetn             (resetn),
    .module_input_clock (module_input_clock),
    .cfg                (clk_bus.gen)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Event sources after masking
  always_comb begin
    gpio_dir    = dev_set_ff[scmcir_pkg::BIT_DIR_LSB +: 4];
    // Only pins set as inputs report a change
    gpio_change = (gpio_sync_ff ^ gpio_prev_ff) & gpio_dir;
    set_bits    = 8'h00;
    set_bits[scmcir_pkg::BIT_SUM_UC]   = |(user_card_flags &
        ~{mask_uc_ff[7], mask_uc_ff[6], mask_uc_ff[5], mask_m12_ff[0], mask_uc_ff[0]});
    set_bits[scmcir_pkg::BIT_SUM_M1]   = |(first_module_flags &
        ~{mask_m12_ff[7], mask_m12_ff[6], mask_m12_ff[5], mask_m12_ff[1]});
    set_bits[scmcir_pkg::BIT_SUM_M2]   = |(second_module_flags &
        ~{mask_m12_ff[4], mask_m12_ff[3], mask_m12_ff[2], mask_m12_ff[1]});
    set_bits[scmcir_pkg::BIT_SUM_M3]   = |(third_module_flags &
        ~{mask_m3_ff[7], mask_m3_ff[6], mask_m3_ff[5], mask_m12_ff[1]});
    set_bits[scmcir_pkg::BIT_SUM_OTP]  = over_temp_event & ~mask_uc_ff[3];
    set_bits[scmcir_pkg::BIT_SUM_SUPL] = supervisor_fault_event & ~mask_uc_ff[2];
    set_bits[scmcir_pkg::BIT_SUM_SYNC] = sync_complete_event & ~mask_uc_ff[4];
    set_bits[scmcir_pkg::BIT_SUM_GPIO] = |(gpio_change & ~mask_m3_ff[4:1]) & ~mask_uc_ff[1];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register access and next state
  always_comb begin
    nxt_clk_sel    = clk_sel_ff;
    nxt_soon_hi    = soon_hi_ff;
    nxt_soon_lo    = soon_lo_ff;
    nxt_silence_hi = silence_hi_ff;
    nxt_silence_lo = silence_lo_ff;
    nxt_dev_set    = dev_set_ff;
    nxt_gpio_lvl   = gpio_lvl_ff;
    nxt_mask_uc    = mask_uc_ff;
    nxt_mask_m12   = mask_m12_ff;
    nxt_mask_m3    = mask_m3_ff;
    nxt_rdata      = rdata_ff;
    nxt_rvalid     = reg_rd;

    if (reg_wr) begin
      if (hit(reg_addr, scmcir_pkg::OFS_CLK_SEL)) begin
        nxt_clk_sel = {reg_wdata[7:2], 2'h0};
      end
      if (hit(reg_addr, scmcir_pkg::OFS_SOON_HI)) begin
        nxt_soon_hi = reg_wdata;
      end
      if (hit(reg_addr, scmcir_pkg::OFS_SOON_LO)) begin
        nxt_soon_lo = reg_wdata[scmcir_pkg::BIT_SOON_LO_LSB +: 2];
      end
      if (hit(reg_addr, scmcir_pkg::OFS_SILENCE_HI)) begin
        nxt_silence_hi = reg_wdata;
      end
      if (hit(reg_addr, scmcir_pkg::OFS_SILENCE_LO)) begin
        nxt_silence_lo = reg_wdata;
      end
      if (hit(reg_addr, scmcir_pkg::OFS_DEV_SET)) begin
        nxt_dev_set = {reg_wdata[7], 1'b0, reg_wdata[5:2], 2'h0};
      end
      if (hit(reg_addr, scmcir_pkg::OFS_GPIO)) begin
        nxt_gpio_lvl = reg_wdata[3:0];
      end
      if (hit(reg_addr, scmcir_pkg::OFS_MASK_UC)) begin
        nxt_mask_uc = reg_wdata;
      end
      if (hit(reg_addr, scmcir_pkg::OFS_MASK_M12)) begin
        nxt_mask_m12 = reg_wdata;
      end
      if (hit(reg_addr, scmcir_pkg::OFS_MASK_M3)) begin
        nxt_mask_m3 = {reg_wdata[7:1], 1'b0};
      end
    end

    if (reg_rd) begin
      case (reg_addr)
        scmcir_pkg::OFS_CLK_SEL:    nxt_rdata = clk_sel_ff;
        scmcir_pkg::OFS_SOON_HI:    nxt_rdata = soon_hi_ff;
        scmcir_pkg::OFS_SOON_LO:    nxt_rdata = {soon_lo_ff, 6'h00};
        scmcir_pkg::OFS_SILENCE_HI: nxt_rdata = silence_hi_ff;
        scmcir_pkg::OFS_SILENCE_LO: nxt_rdata = silence_lo_ff;
        scmcir_pkg::OFS_VERSION:    nxt_rdata = VERSION_CODE;
        scmcir_pkg::OFS_SUMMARY:    nxt_rdata = summary_ff;
        scmcir_pkg::OFS_DEV_SET:    nxt_rdata = dev_set_ff;
        scmcir_pkg::OFS_GPIO:       nxt_rdata = {gpio_sync_ff, gpio_lvl_ff};
        scmcir_pkg::OFS_MASK_UC:    nxt_rdata = mask_uc_ff;
        scmcir_pkg::OFS_MASK_M12:   nxt_rdata = mask_m12_ff;
        scmcir_pkg::OFS_MASK_M3:    nxt_rdata = mask_m3_ff;
        default:                    nxt_rdata = 8'h00;
      endcase
    end

    // A source still present re-sets its bit; a set in the read cycle survives
    if (reg_rd && hit(reg_addr, scmcir_pkg::OFS_SUMMARY)) begin
      nxt_summary = set_bits;
    end else begin
      nxt_summary = summary_ff | set_bits;
    end
    // Pin follows the next summary so it tracks the register in the same cycle
    nxt_int_n = ~(|nxt_summary);

    // Output pins are released while set as inputs; the level bit is kept
    nxt_gpio_oe  = ~nxt_dev_set[scmcir_pkg::BIT_DIR_LSB +: 4];
    nxt_gpio_out = nxt_gpio_lvl & nxt_gpio_oe;
  end

  always_ff @(posedge clk) begin
    gpio_meta_ff <= gpio_in;
    gpio_sync_ff <= gpio_meta_ff;
    if (!resetn) begin
      clk_sel_ff    <= scmcir_pkg::RST_CLK_SEL;
      soon_hi_ff    <= scmcir_pkg::RST_SOON_HI;
      soon_lo_ff    <= scmcir_pkg::RST_SOON_LO;
      silence_hi_ff <= scmcir_pkg::RST_SILENCE_HI;
      silence_lo_ff <= scmcir_pkg::RST_SILENCE_LO;
      summary_ff    <= 8'h00;
      dev_set_ff    <= scmcir_pkg::RST_DEV_SET;
      gpio_lvl_ff   <= scmcir_pkg::RST_GPIO_OUT;
      mask_uc_ff    <= scmcir_pkg::RST_MASK;
      mask_m12_ff   <= scmcir_pkg::RST_MASK;
      mask_m3_ff    <= scmcir_pkg::RST_MASK;
      rdata_ff      <= 8'h00;
      rvalid_ff     <= 1'b0;
      int_n_ff      <= 1'b1;
      gpio_out_ff   <= 4'h0;
      gpio_oe_ff    <= 4'h0;
      gpio_prev_ff  <= 4'h0;
    end else begin
      clk_sel_ff    <= nxt_clk_sel;
      soon_hi_ff    <= nxt_soon_hi;
      soon_lo_ff    <= nxt_soon_lo;
      silence_hi_ff <= nxt_silence_hi;
      silence_lo_ff <= nxt_silence_lo;
      summary_ff    <= nxt_summary;
      dev_set_ff    <= nxt_dev_set;
      gpio_lvl_ff   <= nxt_gpio_lvl;
      mask_uc_ff    <= nxt_mask_uc;
      mask_m12_ff   <= nxt_mask_m12;
      mask_m3_ff    <= nxt_mask_m3;
      rdata_ff      <= nxt_rdata;
      rvalid_ff     <= nxt_rvalid;
      int_n_ff      <= nxt_int_n;
      gpio_out_ff   <= nxt_gpio_out;
      gpio_oe_ff    <= nxt_gpio_oe;
      gpio_prev_ff  <= gpio_sync_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata                   = rdata_ff;
  assign reg_rvalid                  = rvalid_ff;
  assign int_n                       = int_n_ff;
  assign gpio_out                    = gpio_out_ff;
  assign gpio_oe                     = gpio_oe_ff;
  assign boost_converter_enable      = dev_set_ff[scmcir_pkg::BIT_BOOST_EN];
  assign third_module_card_clock     = clk_bus.card_clock;
  assign third_module_soon_window    = {soon_hi_ff, soon_lo_ff};
  assign third_module_silence_window = {silence_hi_ff, silence_lo_ff};

endmodule

// ---- scmcir_pkg.sv ----
// Shared constants for the smartcard module clock and interrupt register slice
package scmcir_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_CLK_SEL    = 8'h32;
  localparam logic [7:0] OFS_SOON_HI    = 8'h33;
  localparam logic [7:0] OFS_SOON_LO    = 8'h34;
  localparam logic [7:0] OFS_SILENCE_HI = 8'h35;
  localparam logic [7:0] OFS_SILENCE_LO = 8'h36;
  localparam logic [7:0] OFS_VERSION    = 8'h40;
  localparam logic [7:0] OFS_SUMMARY    = 8'h41;
  localparam logic [7:0] OFS_DEV_SET    = 8'h42;
  localparam logic [7:0] OFS_GPIO       = 8'h43;
  localparam logic [7:0] OFS_MASK_UC    = 8'h44;
  localparam logic [7:0] OFS_MASK_M12   = 8'h45;
  localparam logic [7:0] OFS_MASK_M3    = 8'h46;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_OSC_SEL     = 7;
  localparam int BIT_FORCE_LOW   = 6;
  localparam int BIT_FORCE_HIGH  = 5;
  localparam int BIT_DIV_LSB     = 2;
  localparam int BIT_SOON_LO_LSB = 6;
  localparam int BIT_BOOST_EN    = 7;
  localparam int BIT_DIR_LSB     = 2;
  localparam int BIT_GPIO_IN_LSB = 4;
  localparam int BIT_SUM_UC      = 7;
  localparam int BIT_SUM_M1      = 6;
  localparam int BIT_SUM_M2      = 5;
  localparam int BIT_SUM_M3      = 4;
  localparam int BIT_SUM_OTP     = 3;
  localparam int BIT_SUM_SUPL    = 2;
  localparam int BIT_SUM_SYNC    = 1;
  localparam int BIT_SUM_GPIO    = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_CLK_SEL    = 8'h0c;
  localparam logic [7:0] RST_SOON_HI    = 8'haa;
  localparam logic [1:0] RST_SOON_LO    = 2'h0;
  localparam logic [7:0] RST_SILENCE_HI = 8'ha4;
  localparam logic [7:0] RST_SILENCE_LO = 8'h74;
  localparam logic [7:0] RST_DEV_SET    = 8'h80;
  localparam logic [3:0] RST_GPIO_OUT   = 4'hf;
  localparam logic [7:0] RST_MASK       = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Internal oscillator timing
  localparam int CLK_FREQ_KHZ    = 10000;
  localparam int OSC_FREQ_KHZ    = 1200;
  localparam int OSC_HALF_CYCLES = (CLK_FREQ_KHZ / (2 * OSC_FREQ_KHZ)) < 1 ? 1 :
                                   (CLK_FREQ_KHZ / (2 * OSC_FREQ_KHZ));

  typedef enum logic [1:0] {
    SCMCIR_SRC_DIV  = 2'b00,
    SCMCIR_SRC_LOW  = 2'b01,
    SCMCIR_SRC_HIGH = 2'b10,
    SCMCIR_SRC_OSC  = 2'b11
  } scmcir_src_e;

endpackage

// ---- scmcir_clk_if.sv ----
// Settings and result between the register slice and the card clock generator
`timescale 1ns/100ps
interface scmcir_clk_if;
  logic       osc_select;
  logic       force_low;
  logic       force_high;
  logic [2:0] divider;
  logic       card_clock;

  modport ctrl (output osc_select, output force_low, output force_high, output divider, input card_clock);
  modport gen  (input osc_select, input force_low, input force_high, input divider, output card_clock);
endinterface

// ---- scmcir_clkgen.sv ----
// Third module card clock generator: oscillator, forced levels and divider
`timescale 1ns/100ps
module scmcir_clkgen #(
  parameter int CNT_W = 4
) (
  input  wire logic   clk,
  input  wire logic   resetn,
  input  wire logic   module_input_clock,
  scmcir_clk_if.gen   cfg
);

  generate
    if (CNT_W < 4) begin : g_chk
      $error("CNT_W must hold a count of 2*8 input edges");
    end
  endgenerate

  // Edges of the input clock counted modulo 2N; output high for the first N
  function automatic logic [CNT_W-1:0] div_ratio(input logic [2:0] code);
    case (code)
      3'h0:    div_ratio = CNT_W'(1);
      3'h1:    div_ratio = CNT_W'(2);
      3'h2:    div_ratio = CNT_W'(4);
      3'h3:    div_ratio = CNT_W'(5);
      default: div_ratio = CNT_W'(8);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic             in_meta_ff, in_sync_ff, in_prev_ff;
  logic [CNT_W-1:0] edge_cnt_ff, nxt_edge_cnt;
  logic [2:0]       osc_cnt_ff, nxt_osc_cnt;
  logic             osc_ff, nxt_osc;
  logic             clk_out_ff, nxt_clk_out;
  logic [CNT_W-1:0] ratio;
  scmcir_pkg::scmcir_src_e src;

  always_comb begin
    ratio        = div_ratio(cfg.divider);
    nxt_edge_cnt = edge_cnt_ff;
    nxt_osc_cnt  = osc_cnt_ff + 3'h1;
    nxt_osc      = osc_ff;
    if (osc_cnt_ff >= 3'(scmcir_pkg::OSC_HALF_CYCLES - 1)) begin
      nxt_osc_cnt = 3'h0;
      nxt_osc     = ~osc_ff;
    end
    // Both input edges advance the count, so odd ratios keep an exact period
    if (in_sync_ff != in_prev_ff) begin
      if (edge_cnt_ff >= CNT_W'((2 * ratio) - 1)) begin
        nxt_edge_cnt = '0;
      end else begin
        nxt_edge_cnt = edge_cnt_ff + CNT_W'(1);
      end
    // One extra bit: twice the /8 ratio does not fit the count width
    end else if ({1'b0, edge_cnt_ff} >= {ratio, 1'b0}) begin
      nxt_edge_cnt = '0;
    end
    if (cfg.osc_select) begin
      src = scmcir_pkg::SCMCIR_SRC_OSC;
    end else if (cfg.force_low) begin
      src = scmcir_pkg::SCMCIR_SRC_LOW;
    end else if (cfg.force_high) begin
      src = scmcir_pkg::SCMCIR_SRC_HIGH;
    end else begin
      src = scmcir_pkg::SCMCIR_SRC_DIV;
    end
    case (src)
      scmcir_pkg::SCMCIR_SRC_OSC:  nxt_clk_out = osc_ff;
      scmcir_pkg::SCMCIR_SRC_LOW:  nxt_clk_out = 1'b0;
      scmcir_pkg::SCMCIR_SRC_HIGH: nxt_clk_out = 1'b1;
      scmcir_pkg::SCMCIR_SRC_DIV:  nxt_clk_out = (nxt_edge_cnt < ratio);
      default:                     nxt_clk_out = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    in_meta_ff <= module_input_clock;
    in_sync_ff <= in_meta_ff;
    if (!resetn) begin
      in_prev_ff  <= 1'b0;
      edge_cnt_ff <= '0;
      osc_cnt_ff  <= 3'h0;
      osc_ff      <= 1'b0;
      clk_out_ff  <= 1'b0;
    end else begin
      in_prev_ff  <= in_sync_ff;
      edge_cnt_ff <= nxt_edge_cnt;
      osc_cnt_ff  <= nxt_osc_cnt;
      osc_ff      <= nxt_osc;
      clk_out_ff  <= nxt_clk_out;
    end
  end

  assign cfg.card_clock = clk_out_ff;

endmodule

// ---- scmcir_regs_assertions.sv ----
// Concurrent checks on the register slice top ports
`timescale 1ns/100ps
module scmcir_chk (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic [4:0] user_card_flags,
  input wire logic [3:0] first_module_flags,
  input wire logic [3:0] second_module_flags,
  input wire logic [3:0] third_module_flags,
  input wire logic       over_temp_event,
  input wire logic       supervisor_fault_event,
  input wire logic       sync_complete_event,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire logic       int_n,
  input wire logic       third_module_card_clock
);
  logic [7:0] rd_addr_ff;
  logic [7:0] sel_ff;
  logic       mask_wr_ff;
  logic [3:0] osc_age_ff;
  logic [3:0] same_ff;
  logic       card_q_ff;
  logic       any_src;
  assign any_src = |{user_card_flags, first_module_flags, second_module_flags, third_module_flags,
                     over_temp_event, supervisor_fault_event, sync_complete_event};
  ////////////////////////////////////////
  // Shadows of host writes, since the mask and clock settings are not on the ports
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_addr_ff <= 8'h00;
      sel_ff     <= 8'h0c;
      mask_wr_ff <= 1'b0;
      osc_age_ff <= 4'h0;
      same_ff    <= 4'h0;
      card_q_ff  <= 1'b0;
    end else begin
      if (reg_rd) rd_addr_ff <= reg_addr;
      if (reg_wr && reg_addr == 8'h32) sel_ff <= reg_wdata;
      if (reg_wr && reg_addr[7:2] == 6'h11 && reg_addr[1:0] != 2'h3) mask_wr_ff <= 1'b1;
      osc_age_ff <= !sel_ff[7] ? 4'h0 : (osc_age_ff == 4'hf ? osc_age_ff : osc_age_ff + 4'h1);
      same_ff    <= (third_module_card_clock != card_q_ff) ? 4'h0 : (same_ff == 4'hf ? same_ff : same_ff + 4'h1);
      card_q_ff  <= third_module_card_clock;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  AST_RVALID_NEXT: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  AST_OSC_RUNS: assert property (osc_age_ff > 4'h7 |-> same_ff < 4'h5) else $error("oscillator stalled");
  AST_FORCE_LOW: assert property (sel_ff[7:6] == 2'b01 && $stable(sel_ff) |-> !third_module_card_clock)
    else $error("card clock not held low");
  AST_FORCE_HIGH: assert property (sel_ff[7:5] == 3'b001 && $stable(sel_ff) |-> third_module_card_clock)
    else $error("card clock not held high");
  AST_UC_SETS: assert property (!mask_wr_ff && |user_card_flags |=> !int_n)
    else $error("user card flag lost");
  AST_MOD_SETS: assert property (!mask_wr_ff && |{first_module_flags, second_module_flags, third_module_flags}
    |=> !int_n) else $error("module flag lost");
  AST_OTP_SETS: assert property (!mask_wr_ff && over_temp_event |=> !int_n) else $error("thermal event lost");
  AST_SUPL_SETS: assert property (!mask_wr_ff && supervisor_fault_event |=> !int_n)
    else $error("supply lost");
  AST_SYNC_SETS: assert property (!mask_wr_ff && sync_complete_event |=> !int_n)
    else $error("sync event lost");
  AST_PIN_MATCH: assert property (reg_rvalid && rd_addr_ff == 8'h41 |->
    (reg_rdata != 8'h00) == !$past(int_n)) else $error("pin disagrees with summary");
  AST_READ_CLEARS: assert property (reg_rd && reg_addr == 8'h41 && !any_src && gpio_oe == 4'hf |=> int_n)
    else $error("summary not cleared by read");
  AST_OUT_IGNORED: assert property ((gpio_out & ~gpio_oe) == 4'h0) else $error("input pin level driven");
  cover property (reg_rvalid && rd_addr_ff == 8'h41 && reg_rdata != 8'h00);
  cover property (osc_age_ff == 4'hf);
  cover property (mask_wr_ff && |third_module_flags && int_n);
endmodule

// ---- scmcir_host.sv ----
// Host processor model issuing register reads and writes
`timescale 1ns/100ps
module scmcir_host (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  ////////////////////////////////////////
  // Idle bus shows the inverse of the last value, so a stale sample cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking testbench for the register slice
`timescale 1ns/100ps
module tb_top;
  localparam logic [7:0] VERSION_VAL = 8'h3c;  // Arbitrary identification value
  logic        clk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [19:0] src;
  logic [3:0]  gpio_in;
  logic [3:0]  gpio_out;
  logic [3:0]  gpio_oe;
  logic        int_n;
  logic        boost;
  logic [3:0]  mic_cnt = 4'h0;
  logic        card;
  logic [9:0]  soon;
  logic [15:0] silence;
  int          err_count;
  int          check_count;
  scmcir_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
                    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  scmcir_regs #(.VERSION_CODE(VERSION_VAL)) uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .user_card_flags(src[19:15]), .first_module_flags(src[14:11]), .second_module_flags(src[10:7]),
    .third_module_flags(src[6:3]), .over_temp_event(src[2]), .supervisor_fault_event(src[1]),
    .sync_complete_event(src[0]), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .int_n(int_n),
    .boost_converter_enable(boost), .module_input_clock(mic_cnt[3]), .third_module_card_clock(card),
    .third_module_soon_window(soon), .third_module_silence_window(silence));
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk(16'(v), 16'h1);
    chk(16'(d), 16'(exp));
  endtask
  // Module input clock period is 16 cycles, well under half the system rate
  task automatic wait_rise(output int n);
    logic p;
    p = card;
    for (n = 1; n < 2000; n++) begin
      @(posedge clk);
      if (card && !p) return;
      p = card;
    end
    chk(16'h0, 16'h1);
    results;
  endtask
  task automatic period_chk(input logic [7:0] sel, input int exp);
    int n;
    host.wr(8'h32, sel);
    repeat (3) wait_rise(n);
    chk(16'(n), 16'(exp));
  endtask
  task automatic hold_chk(input logic [7:0] sel, input logic lvl);
    host.wr(8'h32, sel);
    repeat (2) @(posedge clk);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      chk(16'(card), 16'(lvl));
    end
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] ad [9] = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h40, 8'h41, 8'h42, 8'h50};
    logic [7:0] ex [9] = '{8'h0c, 8'haa, 8'h00, 8'ha4, 8'h74, VERSION_VAL, 8'h00, 8'h80, 8'h00};
    for (int i = 0; i < 9; i++) rdc(ad[i], ex[i]);
    chk(16'(soon), 16'h02a8);
    chk(silence, 16'ha474);
    chk(16'(boost), 16'h1);
    chk(16'(gpio_oe), 16'h000f);
    chk(16'(int_n), 16'h1);
    $display("t_reset done");
  endtask
  task automatic t_regs;
    host.wr(8'h33, 8'h5c);
    host.wr(8'h34, 8'hff);
    host.wr(8'h35, 8'h12);
    host.wr(8'h36, 8'h9b);
    host.wr(8'h40, 8'hff);
    host.wr(8'h41, 8'hff);
    host.wr(8'h32, 8'hff);
    rdc(8'h34, 8'hc0);
    rdc(8'h36, 8'h9b);
    rdc(8'h40, VERSION_VAL);
    rdc(8'h41, 8'h00);
    rdc(8'h32, 8'hfc);
    chk(16'(soon), 16'h0173);
    chk(silence, 16'h129b);
    $display("t_regs done");
  endtask
  task automatic t_clk;
    int div [8] = '{1, 2, 4, 5, 8, 8, 8, 8};
    hold_chk(8'h60, 1'b0);
    hold_chk(8'h2c, 1'b1);
    period_chk(8'he0, 8);
    for (int i = 0; i < 8; i++) period_chk(8'(i << 2), 16 * div[i]);
    $display("t_clk done");
  endtask
  // Every source flag in turn, from sync completion up to user card
  task automatic t_int;
    logic [7:0] e;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      src <= 20'h1 << i;
      repeat (2) @(posedge clk);
      chk(16'(int_n), 16'h0);
      src <= 20'h0;
      e = (i > 14) ? 8'h80 : (i > 10) ? 8'h40 : (i > 6) ? 8'h20 : (i > 2) ? 8'h10 : 8'(2 << i);
      rdc(8'h41, e);
      chk(16'(int_n), 16'h1);
    end
    src <= 20'h00008;
    repeat (2) @(posedge clk);
    rdc(8'h41, 8'h10);
    chk(16'(int_n), 16'h0);
    src <= 20'h0;
    rdc(8'h41, 8'h10);
    rdc(8'h41, 8'h00);
    chk(16'(int_n), 16'h1);
    $display("t_int done");
  endtask
  task automatic t_gpio;
    int n;
    host.wr(8'h42, 8'h84);
    repeat (3) @(posedge clk);
    chk(16'(gpio_oe), 16'h000e);
    chk(16'(gpio_out), 16'h000e);
    gpio_in <= 4'h1;
    for (n = 0; n < 10 && int_n; n++) @(posedge clk);
    if (n == 10) chk(16'h0, 16'h1);
    if (n == 10) results;
    rdc(8'h41, 8'h01);
    host.wr(8'h43, 8'h00);
    host.wr(8'h42, 8'h3c);
    host.wr(8'h43, 8'h0f);
    repeat (3) @(posedge clk);
    chk(16'(gpio_oe), 16'h0000);
    chk(16'(gpio_out), 16'h0000);
    chk(16'(boost), 16'h0);
    host.wr(8'h42, 8'h80);
    repeat (3) @(posedge clk);
    chk(16'(gpio_out), 16'h000f);
    rdc(8'h41, 8'h00);
    $display("t_gpio done");
  endtask
  task automatic t_mask;
    host.wr(8'h44, 8'hff);
    host.wr(8'h46, 8'he0);
    host.wr(8'h45, 8'h03);
    src <= 20'hf807f;
    repeat (4) @(posedge clk);
    chk(16'(int_n), 16'h1);
    rdc(8'h41, 8'h00);
    rdc(8'h46, 8'he0);
    src <= 20'h0;
    $display("t_mask done");
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) mic_cnt <= mic_cnt + 4'h1;
  initial begin
    resetn      = 1'b0;
    src         = 20'h0;
    gpio_in     = 4'h0;
    err_count   = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_regs;
    t_clk;
    t_int;
    t_gpio;
    t_mask;
    results;
  end
endmodule
bind scmcir_regs scmcir_chk u_chk (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
  .user_card_flags, .first_module_flags, .second_module_flags, .third_module_flags, .over_temp_event,
  .supervisor_fault_event, .sync_complete_event, .gpio_out, .gpio_oe, .int_n, .third_module_card_clock);
